/* rtl/dioch_pkg.sv */
// dioch_pkg: constants shared by the eight-channel digital i/o block
// assumes a 40 MHz system clock
package dioch_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int FILT_FAST_US = 1;
  localparam int FILT_SLOW_US = 125;
  localparam int FILT_FAST_CYC = FILT_FAST_US * CLK_MHZ;
  localparam int FILT_SLOW_CYC = FILT_SLOW_US * CLK_MHZ;
  localparam int FILT_CNT_W = 13;

  // ------------------------------------------------------------
  // channel modes
  // ------------------------------------------------------------
  typedef enum logic [0:0] {
    MODE_PLAIN_INPUT = 1'b0,
    MODE_PLAIN_OUTPUT = 1'b1
  } dioch_mode_e;

  localparam int NUM_CH = 8;
  localparam int PRIO_W = 5;
  localparam int EVT_W = 4;
  localparam logic [3:0] EVT_NONE = 4'h0;
  localparam logic EDGE_RISE = 1'b0;
  localparam logic EDGE_FALL = 1'b1;

endpackage : dioch_pkg

/* rtl/dioch_filter.sv */
// dioch_filter: one channel's input delay filter
// assumes pin is synchronous to mclk
`timescale 1ns/1ps
module dioch_filter
#(
  parameter int FAST_CYC = dioch_pkg::FILT_FAST_CYC,
  parameter int SLOW_CYC = dioch_pkg::FILT_SLOW_CYC
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // data
  input wire logic din,
  input wire logic slow_sel,
  output logic dout
);

  logic [dioch_pkg::FILT_CNT_W-1:0] cnt;
  logic [dioch_pkg::FILT_CNT_W-1:0] limit;

  assign limit = slow_sel ? dioch_pkg::FILT_CNT_W'(SLOW_CYC - 1)
                          : dioch_pkg::FILT_CNT_W'(FAST_CYC - 1);

  // ------------------------------------------------------------
  // accept a new level after it stands for the delay time
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cnt <= '0;
      dout <= 1'b0;
    end
    else if (din == dout)
      cnt <= '0;
    else if (cnt >= limit)
    begin
      dout <= din;
      cnt <= '0;
    end
    else
      cnt <= cnt + 1'b1;
  end

endmodule : dioch_filter

/* rtl/dioch_top.sv */
// dioch_top: eight-channel digital input/output with edge interrupts
// assumes pins synchronous to mclk, settings held static by the program
`timescale 1ns/1ps
module dioch_top
#(
  parameter int NCH = dioch_pkg::NUM_CH,
  parameter int FAST_CYC = dioch_pkg::FILT_FAST_CYC,
  parameter int SLOW_CYC = dioch_pkg::FILT_SLOW_CYC
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // per-channel settings from the program
  input wire logic [NCH-1:0] mode_out,
  input wire logic [NCH-1:0] invert,
  input wire logic [NCH-1:0] delay_slow,
  input wire logic [NCH-1:0] rise_en,
  input wire logic [NCH-1:0] fall_en,
  input wire logic [NCH-1:0] high_speed,
  input wire logic [NCH*dioch_pkg::PRIO_W-1:0] rise_prio,
  input wire logic [NCH*dioch_pkg::PRIO_W-1:0] fall_prio,
  input wire logic cfg_load,
  // program data
  input wire logic [NCH-1:0] out_bit,
  output logic [NCH-1:0] in_bit,
  // field pins
  input wire logic [NCH-1:0] pin_in,
  output logic [NCH-1:0] pin_out,
  output logic [NCH-1:0] pin_oe,
  output logic [NCH-1:0] pin_fast,
  // interrupt to the edge_interrupt_handler
  output logic irq,
  output logic [dioch_pkg::EVT_W-1:0] irq_event,
  output logic [dioch_pkg::PRIO_W-1:0] irq_prio,
  input wire logic irq_ack
);

  // ------------------------------------------------------------
  // configuration latch, defaults to plain input
  // ------------------------------------------------------------
  logic [NCH-1:0] cfg_out, cfg_inv, cfg_slow, cfg_rise, cfg_fall, cfg_hs;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cfg_out <= '0;
      cfg_inv <= '0;
      cfg_slow <= '1;
      cfg_rise <= '0;
      cfg_fall <= '0;
      cfg_hs <= '0;
    end
    else if (cfg_load)
    begin
      cfg_out <= mode_out;
      cfg_inv <= invert;
      cfg_slow <= delay_slow;
      cfg_rise <= rise_en;
      cfg_fall <= fall_en;
      cfg_hs <= high_speed;
    end
  end

  // ------------------------------------------------------------
  // per-channel datapath
  // ------------------------------------------------------------
  logic [NCH-1:0] filt, filt_q, rise_hit, fall_hit;

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      dioch_filter #(.FAST_CYC(FAST_CYC), .SLOW_CYC(SLOW_CYC)) u_filt
      (
        .mclk(mclk),
        .rst_n(rst_n),
        .din(pin_in[g]),
        .slow_sel(cfg_slow[g]),
        .dout(filt[g])
      );
      // edges taken on the raw filtered pin, before inversion
      assign rise_hit[g] = !cfg_out[g] && cfg_rise[g] && filt[g] && !filt_q[g];
      assign fall_hit[g] = !cfg_out[g] && cfg_fall[g] && !filt[g] && filt_q[g];
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      filt_q <= '0;
      in_bit <= '0;
    end
    else
    begin
      filt_q <= filt;
      in_bit <= (filt ^ cfg_inv) & ~cfg_out;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pin_out <= '0;
      pin_oe <= '0;
      pin_fast <= '0;
    end
    else
    begin
      pin_out <= (out_bit ^ cfg_inv) & cfg_out;
      pin_oe <= cfg_out;
      pin_fast <= cfg_hs & cfg_out;
    end
  end

  // ------------------------------------------------------------
  // pending events and interrupt selection
  // ------------------------------------------------------------
  logic [2*NCH-1:0] pend, hit;
  logic [2*NCH-1:0] clr;
  logic sel_vld;
  logic [dioch_pkg::EVT_W-1:0] sel_evt;
  logic [dioch_pkg::PRIO_W-1:0] sel_prio;

  assign hit = {fall_hit, rise_hit};

  // highest priority value wins, lowest index on tie
  always_comb
  begin
    logic [dioch_pkg::PRIO_W-1:0] p;
    p = '0;
    sel_vld = 1'b0;
    sel_evt = dioch_pkg::EVT_NONE;
    sel_prio = '0;
    for (int i = 0; i < 2*NCH; i++)
    begin
      if (pend[i])
      begin
        p = (i < NCH) ? rise_prio[(i%NCH)*dioch_pkg::PRIO_W +: dioch_pkg::PRIO_W]
                      : fall_prio[(i%NCH)*dioch_pkg::PRIO_W +: dioch_pkg::PRIO_W];
        if (!sel_vld || p > sel_prio)
        begin
          sel_vld = 1'b1;
          sel_prio = p;
          sel_evt = dioch_pkg::EVT_W'(i);
        end
      end
    end
  end

  always_comb
  begin
    clr = '0;
    if (irq && irq_ack)
      clr[irq_event] = 1'b1;
  end

  // set wins over clear
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      pend <= '0;
    else
      pend <= (pend & ~clr) | hit;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      irq <= 1'b0;
      irq_event <= dioch_pkg::EVT_NONE;
      irq_prio <= '0;
    end
    else if (!irq || irq_ack)
    begin
      irq <= sel_vld && !(clr == (2*NCH)'(1) << sel_evt && sel_vld && irq);
      irq_event <= sel_evt;
      irq_prio <= sel_prio;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_reset_input_mode: assert property (@(posedge mclk) !rst_n |=> pin_oe == '0)
    else $error("channels not in input mode after reset");
  chk_input_invert: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg_out == '0) |=> in_bit == (($past(filt) ^ $past(cfg_inv))))
    else $error("input bit does not follow filtered pin and invert");
  chk_output_invert: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> pin_out == (($past(out_bit) ^ $past(cfg_inv)) & $past(cfg_out)))
    else $error("pin output wrong");
  chk_fast_drive: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> pin_fast == ($past(cfg_hs) & $past(cfg_out)))
    else $error("high-speed drive wrong");
  chk_rise_pending: assert property (@(posedge mclk) disable iff (!rst_n)
    (rise_hit != '0) |=> (pend[NCH-1:0] & $past(rise_hit)) == $past(rise_hit))
    else $error("rising edge lost");
  chk_fall_pending: assert property (@(posedge mclk) disable iff (!rst_n)
    (fall_hit != '0) |=> (pend[2*NCH-1:NCH] & $past(fall_hit)) == $past(fall_hit))
    else $error("falling edge lost");
  chk_irq_raised: assert property (@(posedge mclk) disable iff (!rst_n)
    (pend != '0 && !irq) |=> irq)
    else $error("interrupt not raised for pending event");
  chk_irq_event: assert property (@(posedge mclk) disable iff (!rst_n)
    irq |-> pend[irq_event])
    else $error("interrupt identity not pending");
  // a changed filter bit must match a pin level that stood two samples
  chk_filter_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |-> ((filt ^ $past(filt)) & ((filt ^ $past(pin_in))
      | ($past(pin_in) ^ $past(pin_in, 2)))) == '0)
    else $error("filter output changed without pin level");

endmodule : dioch_top

/* bench/dioch_field.sv */
// dioch_field: field wiring and sensors on the eight pins
// assumes pins sampled on the mclk rising edge
`timescale 1ns/1ps
module dioch_field
(
  // clock
  input wire logic mclk,
  // pins
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  output logic [7:0] pin_in
);
  logic [7:0] sensor = 8'h00;
  // driven channels read back their own drive
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & sensor);

  task automatic set_lvl(input int ch, input logic v);
    @(posedge mclk);
    #2 sensor[ch] = v;
  endtask : set_lvl
endmodule : dioch_field

/* bench/digital_io_channel_edge_irq_tb_top.sv */
// testbench for dioch_top with short filter counts
// assumes dioch_field model on the pins
`timescale 1ns/1ps
module digital_io_channel_edge_irq_tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_load = 1'b0;
  logic irq_ack = 1'b0;
  logic [7:0] mode_out = 8'h00, invert = 8'h00, delay_slow = 8'h00, high_speed = 8'h00;
  logic [7:0] rise_en = 8'h00, fall_en = 8'h00, out_bit = 8'h00;
  logic [39:0] rise_prio = 40'h00_0000_0000, fall_prio = 40'h00_0000_0000;
  logic [7:0] in_bit, pin_in, pin_out, pin_oe, pin_fast;
  logic irq;
  logic [3:0] irq_event;
  logic [4:0] irq_prio;
  int n_fail = 0;
  int checked = 0;

  always #12.5 mclk = ~mclk;

  dioch_top #(.NCH(8), .FAST_CYC(2), .SLOW_CYC(6)) i_dut (.mclk(mclk), .rst_n(rst_n),
    .mode_out(mode_out), .invert(invert), .delay_slow(delay_slow), .rise_en(rise_en),
    .fall_en(fall_en), .high_speed(high_speed), .rise_prio(rise_prio),
    .fall_prio(fall_prio), .cfg_load(cfg_load), .out_bit(out_bit), .in_bit(in_bit),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_fast(pin_fast), .irq(irq),
    .irq_event(irq_event), .irq_prio(irq_prio), .irq_ack(irq_ack));
  dioch_field i_field (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : cyc

  task automatic cfg();
    cfg_load = 1'b1;
    cyc(1);
    cfg_load = 1'b0;
  endtask : cfg

  task automatic irq_take(input logic [3:0] ev, input logic [4:0] pr);
    int i;
    i = 0;
    while (irq !== 1'b1 && i < 30)
    begin
      cyc(1);
      i++;
    end
    chk("irq", {7'h00, irq}, 8'h01);
    chk("event", {4'h0, irq_event}, {4'h0, ev});
    chk("prio", {3'h0, irq_prio}, {3'h0, pr});
    irq_ack = 1'b1;
    cyc(1);
    irq_ack = 1'b0;
    cyc(1);
    chk("irq", {7'h00, irq}, 8'h00);
  endtask : irq_take

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    cyc(4);
    rst_n = 1'b1;
    cyc(1);
    chk("pin_oe", pin_oe, 8'h00);
    chk("in_bit", in_bit, 8'h00);
    $display("test reset done");
    invert = 8'h02;
    delay_slow = 8'h04;
    rise_en = 8'h08;
    fall_en = 8'h20;
    rise_prio[19:15] = 5'h09;
    fall_prio[29:25] = 5'h14;
    cfg();
    cyc(8);
    chk("in_bit", in_bit, 8'h02);
    i_field.set_lvl(2, 1'b1);
    cyc(3);
    i_field.set_lvl(2, 1'b0);
    i_field.set_lvl(3, 1'b1);
    i_field.set_lvl(3, 1'b0);
    cyc(12);
    chk("in_bit", in_bit, 8'h02);
    chk("irq", {7'h00, irq}, 8'h00);
    i_field.set_lvl(2, 1'b1);
    cyc(5);
    chk("in_bit", in_bit, 8'h02);
    cyc(6);
    chk("in_bit", in_bit, 8'h06);
    $display("test filter done");
    i_field.set_lvl(3, 1'b1);
    irq_take(4'h3, 5'h09);
    i_field.set_lvl(3, 1'b0);
    i_field.set_lvl(5, 1'b1);
    cyc(12);
    chk("irq", {7'h00, irq}, 8'h00);
    i_field.set_lvl(5, 1'b0);
    irq_take(4'hd, 5'h14);
    $display("test edges done");
    mode_out = 8'hc0;
    invert = 8'h42;
    high_speed = 8'h80;
    cfg();
    cyc(2);
    chk("pin_oe", pin_oe, 8'hc0);
    chk("pin_fast", pin_fast, 8'h80);
    chk("pin_out", pin_out, 8'h40);
    chk("in_bit", in_bit, 8'h06);
    out_bit = 8'hc0;
    cyc(1);
    chk("pin_out", pin_out, 8'h80);
    out_bit = 8'h00;
    cyc(1);
    chk("pin_out", pin_out, 8'h40);
    $display("test output done");
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    cyc(1);
    chk("pin_oe", pin_oe, 8'h00);
    chk("pin_out", pin_out, 8'h00);
    chk("pin_fast", pin_fast, 8'h00);
    chk("in_bit", in_bit, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
    cyc(5);
    chk("in_bit", in_bit, 8'h00);
    cyc(1);
    chk("in_bit", in_bit, 8'h04);
    $display("test reset again done");
    stop_test();
  end

  initial
  begin
    #(25 * 2000);
    n_fail++;
    stop_test();
  end
endmodule : digital_io_channel_edge_irq_tb_top
